// >>> sbai_pkg.sv
// package for the state base address indirection block
// assumes a single engine clock and a plain register port
package sbai_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SBAI_ADDR_W = 48;
  localparam int SBAI_REG_AW = 8;
  localparam int SBAI_DATA_W = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SBAI_OFS_GEN_LO = 8'h00;
  localparam logic [7:0] SBAI_OFS_GEN_HI = 8'h04;
  localparam logic [7:0] SBAI_OFS_DYN_LO = 8'h08;
  localparam logic [7:0] SBAI_OFS_DYN_HI = 8'h0c;
  localparam logic [7:0] SBAI_OFS_INS_LO = 8'h10;
  localparam logic [7:0] SBAI_OFS_INS_HI = 8'h14;
  localparam logic [7:0] SBAI_OFS_SUR_LO = 8'h18;
  localparam logic [7:0] SBAI_OFS_SUR_HI = 8'h1c;
  localparam logic [7:0] SBAI_OFS_IND_LO = 8'h20;
  localparam logic [7:0] SBAI_OFS_IND_HI = 8'h24;
  localparam logic [7:0] SBAI_OFS_MODE = 8'h28;
  localparam logic [7:0] SBAI_OFS_STATUS = 8'h2c;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int SBAI_MODE_CB_DIS_BIT = 0;
  localparam logic [47:0] SBAI_BASE_RESET = 48'h0000_0000_0000;
  localparam logic [31:0] SBAI_ZERO_WORD = 32'h0000_0000;
  localparam int SBAI_HI_W = 16;
  localparam int SBAI_CNT_W = 16;
  localparam int SBAI_SEL_LSB = 16;
  localparam int SBAI_SEL_W = 3;
  localparam logic [SBAI_CNT_W-1:0] SBAI_CNT_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // access paths seen on the request port
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SBAI_P_DP_STATELESS = 5'h00,
    SBAI_P_SAMP_STATE = 5'h01,
    SBAI_P_VIEWPORT = 5'h02,
    SBAI_P_CC_DS_BLEND = 5'h03,
    SBAI_P_PUSH_CONST = 5'h04,
    SBAI_P_EU_NORMAL = 5'h05,
    SBAI_P_EU_SYSTEM = 5'h06,
    SBAI_P_BIND_TABLE = 5'h07,
    SBAI_P_SURF_STATE = 5'h08,
    SBAI_P_MEDIA_IND = 5'h09,
    SBAI_P_RING_BATCH = 5'h0a,
    SBAI_P_SYNC_WRITE = 5'h0b,
    SBAI_P_VERTEX = 5'h0c,
    SBAI_P_TEXTURE = 5'h0d,
    SBAI_P_DP_OTHER = 5'h0e,
    SBAI_P_PRELOAD = 5'h0f,
    SBAI_P_PHYSICAL = 5'h10
  } sbai_path_type;

  // which base a path resolves to
  typedef enum logic [2:0] {
    SBAI_B_NONE = 3'h0,
    SBAI_B_GENERAL = 3'h1,
    SBAI_B_DYNAMIC = 3'h2,
    SBAI_B_INSTR = 3'h3,
    SBAI_B_SURFACE = 3'h4,
    SBAI_B_INDIRECT = 3'h5
  } sbai_base_sel_type;

  // a request from an engine client
  typedef struct packed {
    logic valid;
    sbai_path_type path;
    logic write;
    logic [SBAI_ADDR_W-1:0] offset;
  } sbai_req_type;

  // a request toward the translated memory path
  typedef struct packed {
    logic valid;
    logic write;
    logic translate;
    sbai_base_sel_type base_sel;
    logic [SBAI_ADDR_W-1:0] addr;
  } sbai_mem_type;

  // register port command
  typedef struct packed {
    logic wr;
    logic rd;
    logic [SBAI_REG_AW-1:0] addr;
    logic [SBAI_DATA_W-1:0] wdata;
  } sbai_reg_cmd_type;

endpackage

// >>> sbai_indirection.sv
// state base address indirection: base registers and address generator
// assumes requests arrive from logic on ref_clk_in, one per cycle, no stall
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - selected base is always added; zero base makes address equal offset
// - stateless data port accesses use the general state base
// - sampler state and edge colour record reads use dynamic state base
// - viewport state for clipper, setup, windower stages uses dynamic base
// - colour calc, z and mask test, mixing records use dynamic base
// - push constants use dynamic base or none, per parser mode bit
// - normal execution unit code uses instruction base
// - system routine code uses instruction base at system routine pointer
// - binding table reads use surface state base
// - surface state record reads use surface state base
// - media object indirect data uses indirect object base
// - pipeline sync command writes use absolute addresses
// - all vertex fetch accesses use absolute addresses
// - sampler texture data accesses use absolute addresses
// - state preload command reads add no base
// - any other translated access defaults to absolute address
// - base plus offset gives a virtual address that is translated
// - physical addresses bypass translation; absolute ones are translated
module sbai_indirection (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire sbai_pkg::sbai_req_type req_in,
  input wire sbai_pkg::sbai_reg_cmd_type reg_cmd_in,
  output logic [sbai_pkg::SBAI_DATA_W-1:0] reg_rdata_out,
  output sbai_pkg::sbai_mem_type mem_out
);
  import sbai_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SBAI_ADDR_W-1:0] gen_base;
    logic [SBAI_ADDR_W-1:0] dyn_base;
    logic [SBAI_ADDR_W-1:0] ins_base;
    logic [SBAI_ADDR_W-1:0] sur_base;
    logic [SBAI_ADDR_W-1:0] ind_base;
    logic cb_offset_disable;
    logic [SBAI_DATA_W-1:0] rdata;
    sbai_mem_type mem;
    logic [SBAI_CNT_W-1:0] req_count;
    sbai_base_sel_type last_sel;
  } sbai_state_type;

  sbai_state_type state;
  sbai_state_type next_state;

  // ----------------------------------------------------------------
  // register identities
  // ----------------------------------------------------------------
  // one code per mapped word, shared by the write and read paths
  typedef enum logic [3:0] {
    SBAI_R_NONE = 4'h0,
    SBAI_R_GEN_LO = 4'h1,
    SBAI_R_GEN_HI = 4'h2,
    SBAI_R_DYN_LO = 4'h3,
    SBAI_R_DYN_HI = 4'h4,
    SBAI_R_INS_LO = 4'h5,
    SBAI_R_INS_HI = 4'h6,
    SBAI_R_SUR_LO = 4'h7,
    SBAI_R_SUR_HI = 4'h8,
    SBAI_R_IND_LO = 4'h9,
    SBAI_R_IND_HI = 4'ha,
    SBAI_R_MODE = 4'hb,
    SBAI_R_STATUS = 4'hc
  } sbai_reg_id_type;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // map an access path to its base; push constants depend on the mode bit
  function automatic sbai_base_sel_type path_to_base(input sbai_path_type path,
                                                     input logic cb_dis);
    sbai_base_sel_type sel;
    sel = SBAI_B_NONE; // default: absolute address
    case (path)
      SBAI_P_DP_STATELESS: begin
        sel = SBAI_B_GENERAL;
      end
      SBAI_P_SAMP_STATE: begin
        sel = SBAI_B_DYNAMIC;
      end
      SBAI_P_VIEWPORT: begin
        sel = SBAI_B_DYNAMIC;
      end
      SBAI_P_CC_DS_BLEND: begin
        sel = SBAI_B_DYNAMIC;
      end
      SBAI_P_PUSH_CONST: begin
        sel = cb_dis ? SBAI_B_NONE : SBAI_B_DYNAMIC;
      end
      SBAI_P_EU_NORMAL: begin
        sel = SBAI_B_INSTR;
      end
      SBAI_P_EU_SYSTEM: begin
        sel = SBAI_B_INSTR;
      end
      SBAI_P_BIND_TABLE: begin
        sel = SBAI_B_SURFACE;
      end
      SBAI_P_SURF_STATE: begin
        sel = SBAI_B_SURFACE;
      end
      SBAI_P_MEDIA_IND: begin
        sel = SBAI_B_INDIRECT;
      end
      SBAI_P_SYNC_WRITE: begin
        sel = SBAI_B_NONE;
      end
      SBAI_P_VERTEX: begin
        sel = SBAI_B_NONE;
      end
      SBAI_P_TEXTURE: begin
        sel = SBAI_B_NONE;
      end
      SBAI_P_PRELOAD: begin
        sel = SBAI_B_NONE;
      end
      default: begin
        sel = SBAI_B_NONE;
      end
    endcase
    return sel;
  endfunction

  // replace the low or high part of a 48-bit base with a written word
  function automatic logic [SBAI_ADDR_W-1:0] put_word(input logic [SBAI_ADDR_W-1:0] base,
                                                      input logic hi,
                                                      input logic [SBAI_DATA_W-1:0] w);
    logic [SBAI_ADDR_W-1:0] r;
    r = base;
    if (hi) begin
      r[SBAI_ADDR_W-1:SBAI_DATA_W] = w[SBAI_HI_W-1:0];
    end else begin
      r[SBAI_DATA_W-1:0] = w;
    end
    return r;
  endfunction

  // read the low or high part of a base, high bits above 47 read zero
  function automatic logic [SBAI_DATA_W-1:0] get_word(input logic [SBAI_ADDR_W-1:0] base,
                                                      input logic hi);
    logic [SBAI_DATA_W-1:0] r;
    r = SBAI_ZERO_WORD;
    if (hi) begin
      r[SBAI_HI_W-1:0] = base[SBAI_ADDR_W-1:SBAI_DATA_W];
    end else begin
      r = base[SBAI_DATA_W-1:0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // decode and address helpers
  // ----------------------------------------------------------------
  // decode a bus address into the word it selects; writes and reads share it
  function automatic sbai_reg_id_type decode_reg(input logic [SBAI_REG_AW-1:0] addr);
    sbai_reg_id_type id;
    id = SBAI_R_NONE;
    case (addr)
      SBAI_OFS_GEN_LO: begin
        id = SBAI_R_GEN_LO;
      end
      SBAI_OFS_GEN_HI: begin
        id = SBAI_R_GEN_HI;
      end
      SBAI_OFS_DYN_LO: begin
        id = SBAI_R_DYN_LO;
      end
      SBAI_OFS_DYN_HI: begin
        id = SBAI_R_DYN_HI;
      end
      SBAI_OFS_INS_LO: begin
        id = SBAI_R_INS_LO;
      end
      SBAI_OFS_INS_HI: begin
        id = SBAI_R_INS_HI;
      end
      SBAI_OFS_SUR_LO: begin
        id = SBAI_R_SUR_LO;
      end
      SBAI_OFS_SUR_HI: begin
        id = SBAI_R_SUR_HI;
      end
      SBAI_OFS_IND_LO: begin
        id = SBAI_R_IND_LO;
      end
      SBAI_OFS_IND_HI: begin
        id = SBAI_R_IND_HI;
      end
      SBAI_OFS_MODE: begin
        id = SBAI_R_MODE;
      end
      SBAI_OFS_STATUS: begin
        id = SBAI_R_STATUS;
      end
      default: begin
        id = SBAI_R_NONE; // unmapped word
      end
    endcase
    return id;
  endfunction

  // value of the chosen base; no base means an absolute address
  function automatic logic [SBAI_ADDR_W-1:0] pick_base(input sbai_state_type s,
    input sbai_base_sel_type sel);
    logic [SBAI_ADDR_W-1:0] b;
    b = SBAI_BASE_RESET;
    case (sel)
      SBAI_B_GENERAL: begin
        b = s.gen_base;
      end
      SBAI_B_DYNAMIC: begin
        b = s.dyn_base;
      end
      SBAI_B_INSTR: begin
        b = s.ins_base;
      end
      SBAI_B_SURFACE: begin
        b = s.sur_base;
      end
      SBAI_B_INDIRECT: begin
        b = s.ind_base;
      end
      default: begin
        b = SBAI_BASE_RESET; // absolute: no base added
      end
    endcase
    return b;
  endfunction

  // plain binary sum; the carry out of the top bit is dropped on purpose
  function automatic logic [SBAI_ADDR_W-1:0] add_offset(input logic [SBAI_ADDR_W-1:0] b,
    input logic [SBAI_ADDR_W-1:0] o);
    logic [SBAI_ADDR_W:0] s;
    s = {1'b0, b} + {1'b0, o};
    return s[SBAI_ADDR_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // register writes, read mux and address generation
  always_comb begin
    sbai_base_sel_type sel;
    sbai_reg_id_type id;
    logic [SBAI_ADDR_W-1:0] base;
    logic [SBAI_DATA_W-1:0] w;
    sel = SBAI_B_NONE;
    id = decode_reg(reg_cmd_in.addr);
    base = SBAI_BASE_RESET;
    w = reg_cmd_in.wdata;
    next_state = state;

    // register writes land at the edge that takes the strobe
    if (reg_cmd_in.wr) begin
      case (id)
        SBAI_R_GEN_LO: begin
          next_state.gen_base = put_word(state.gen_base, 1'b0, w);
        end
        SBAI_R_GEN_HI: begin
          next_state.gen_base = put_word(state.gen_base, 1'b1, w);
        end
        SBAI_R_DYN_LO: begin
          next_state.dyn_base = put_word(state.dyn_base, 1'b0, w);
        end
        SBAI_R_DYN_HI: begin
          next_state.dyn_base = put_word(state.dyn_base, 1'b1, w);
        end
        SBAI_R_INS_LO: begin
          next_state.ins_base = put_word(state.ins_base, 1'b0, w);
        end
        SBAI_R_INS_HI: begin
          next_state.ins_base = put_word(state.ins_base, 1'b1, w);
        end
        SBAI_R_SUR_LO: begin
          next_state.sur_base = put_word(state.sur_base, 1'b0, w);
        end
        SBAI_R_SUR_HI: begin
          next_state.sur_base = put_word(state.sur_base, 1'b1, w);
        end
        SBAI_R_IND_LO: begin
          next_state.ind_base = put_word(state.ind_base, 1'b0, w);
        end
        SBAI_R_IND_HI: begin
          next_state.ind_base = put_word(state.ind_base, 1'b1, w);
        end
        SBAI_R_MODE: begin
          next_state.cb_offset_disable = w[SBAI_MODE_CB_DIS_BIT];
        end
        default: begin
          next_state.cb_offset_disable = state.cb_offset_disable; // write ignored
        end
      endcase
    end

    // read data stands in the cycle after the strobe only
    next_state.rdata = SBAI_ZERO_WORD;
    if (reg_cmd_in.rd) begin
      case (id)
        SBAI_R_GEN_LO: begin
          next_state.rdata = get_word(state.gen_base, 1'b0);
        end
        SBAI_R_GEN_HI: begin
          next_state.rdata = get_word(state.gen_base, 1'b1);
        end
        SBAI_R_DYN_LO: begin
          next_state.rdata = get_word(state.dyn_base, 1'b0);
        end
        SBAI_R_DYN_HI: begin
          next_state.rdata = get_word(state.dyn_base, 1'b1);
        end
        SBAI_R_INS_LO: begin
          next_state.rdata = get_word(state.ins_base, 1'b0);
        end
        SBAI_R_INS_HI: begin
          next_state.rdata = get_word(state.ins_base, 1'b1);
        end
        SBAI_R_SUR_LO: begin
          next_state.rdata = get_word(state.sur_base, 1'b0);
        end
        SBAI_R_SUR_HI: begin
          next_state.rdata = get_word(state.sur_base, 1'b1);
        end
        SBAI_R_IND_LO: begin
          next_state.rdata = get_word(state.ind_base, 1'b0);
        end
        SBAI_R_IND_HI: begin
          next_state.rdata = get_word(state.ind_base, 1'b1);
        end
        SBAI_R_MODE: begin
          next_state.rdata[SBAI_MODE_CB_DIS_BIT] = state.cb_offset_disable;
        end
        SBAI_R_STATUS: begin
          next_state.rdata[SBAI_CNT_W-1:0] = state.req_count;
          next_state.rdata[SBAI_SEL_LSB +: SBAI_SEL_W] = state.last_sel;
        end
        default: begin
          next_state.rdata = SBAI_ZERO_WORD; // unmapped reads zero
        end
      endcase
    end

    // base selection per request, taken from its own path
    sel = path_to_base(req_in.path, state.cb_offset_disable);
    base = pick_base(state, sel);

    // one registered memory request per client request
    next_state.mem.valid = req_in.valid;
    next_state.mem.write = req_in.valid & req_in.write;
    next_state.mem.base_sel = sel;
    // plain sum, wraps at the address width; zero base passes offset through
    next_state.mem.addr = add_offset(base, req_in.offset);
    // only physical accesses skip translation
    next_state.mem.translate = req_in.valid & (req_in.path != SBAI_P_PHYSICAL);
    if (req_in.valid) begin
      next_state.req_count = state.req_count + SBAI_CNT_STEP;
      next_state.last_sel = sel;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // state register, all bases zero after reset
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs come straight from the state flip-flops
  assign reg_rdata_out = state.rdata;
  assign mem_out = state.mem;

endmodule

`default_nettype wire

// >>> sbai_chk.sv
// checker for the base address indirection block
// sees only the ports of sbai_indirection, bound below
`timescale 1ns/100ps
`default_nettype none
module sbai_chk (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire sbai_pkg::sbai_req_type req_in,
  input wire sbai_pkg::sbai_reg_cmd_type reg_cmd_in,
  input wire logic [sbai_pkg::SBAI_DATA_W-1:0] reg_rdata_out,
  input wire sbai_pkg::sbai_mem_type mem_out
);
  import sbai_pkg::*;
  logic [4:0] p;
  // path of this cycle's request, all ones when idle
  assign p = req_in.valid ? req_in.path : 5'h1f;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------------------------------
  // base selection per path except push constants, plus answer, translate flag and read data checks
  // ----------------------------------------------------------------
  property p_one;
    req_in.valid |=> mem_out.valid && mem_out.write == $past(req_in.write);
  endproperty
  property p_gen;
    p == SBAI_P_DP_STATELESS |=> mem_out.base_sel == SBAI_B_GENERAL;
  endproperty
  property p_dyn;
    p inside {[SBAI_P_SAMP_STATE:SBAI_P_CC_DS_BLEND]} |=> mem_out.base_sel == SBAI_B_DYNAMIC;
  endproperty
  property p_ins;
    p inside {SBAI_P_EU_NORMAL, SBAI_P_EU_SYSTEM} |=> mem_out.base_sel == SBAI_B_INSTR;
  endproperty
  property p_sur;
    p inside {SBAI_P_BIND_TABLE, SBAI_P_SURF_STATE} |=> mem_out.base_sel == SBAI_B_SURFACE;
  endproperty
  property p_ind;
    p == SBAI_P_MEDIA_IND |=> mem_out.base_sel == SBAI_B_INDIRECT;
  endproperty
  property p_abs;
    p inside {[SBAI_P_RING_BATCH:SBAI_P_PHYSICAL]}
      |=> mem_out.base_sel == SBAI_B_NONE && mem_out.addr == $past(req_in.offset);
  endproperty
  property p_xlt;
    req_in.valid |=> mem_out.translate == ($past(req_in.path) != SBAI_P_PHYSICAL);
  endproperty
  property p_rd;
    !reg_cmd_in.rd |=> reg_rdata_out == '0;
  endproperty
  a_one: assert property (p_one) else $error("request not answered");
  a_gen: assert property (p_gen) else $error("general base not chosen");
  a_dyn: assert property (p_dyn) else $error("dynamic base not chosen");
  a_ins: assert property (p_ins) else $error("instruction base not chosen");
  a_sur: assert property (p_sur) else $error("surface base not chosen");
  a_ind: assert property (p_ind) else $error("indirect base not chosen");
  a_abs: assert property (p_abs) else $error("base added");
  a_xlt: assert property (p_xlt) else $error("translate flag wrong");
  a_rd: assert property (p_rd) else $error("read data outside its cycle");
  c_push: cover property (p == SBAI_P_PUSH_CONST);
  c_b2b: cover property (req_in.valid [*3]);
  c_rd: cover property (reg_cmd_in.rd ##1 reg_rdata_out != '0);
endmodule
bind sbai_indirection sbai_chk u_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .req_in(req_in), .reg_cmd_in(reg_cmd_in), .reg_rdata_out(reg_rdata_out), .mem_out(mem_out));
`default_nettype wire

// >>> sbai_mem_sink.sv
// model of the translated memory path: takes every transfer, counts them
// assumes one transfer per valid cycle and never stalls the block
`timescale 1ns/100ps
`default_nettype none
module sbai_mem_sink (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire sbai_pkg::sbai_mem_type mem_in,
  output logic [15:0] count_out
);
  import sbai_pkg::*;
  // count accepted transfers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) count_out <= 16'h0000;
    else if (mem_in.valid) count_out <= count_out + 16'h0001;
  end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for sbai_indirection with random back-to-back traffic
// assumes the checker binds itself and the sink models the memory path
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sbai_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  sbai_req_type req_in = '0;
  sbai_reg_cmd_type reg_cmd_in = '0;
  logic [31:0] reg_rdata_out;
  sbai_mem_type mem_out;
  logic [15:0] sink_count;
  logic [47:0] base [6] = '{default: '0};
  logic mode = 1'b0;
  sbai_base_sel_type last_s = SBAI_B_NONE;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_req = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  sbai_indirection DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .req_in(req_in),
    .reg_cmd_in(reg_cmd_in), .reg_rdata_out(reg_rdata_out), .mem_out(mem_out));
  sbai_mem_sink u_sink (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .mem_in(mem_out),
    .count_out(sink_count));
  // ----------------------------------------------------------------
  // expectations and comparisons
  // ----------------------------------------------------------------
  function automatic sbai_mem_type exp_mem(input sbai_req_type r);
    sbai_base_sel_type s;
    case (r.path)
      SBAI_P_DP_STATELESS: s = SBAI_B_GENERAL;
      SBAI_P_SAMP_STATE, SBAI_P_VIEWPORT, SBAI_P_CC_DS_BLEND: s = SBAI_B_DYNAMIC;
      SBAI_P_PUSH_CONST: s = mode ? SBAI_B_NONE : SBAI_B_DYNAMIC;
      SBAI_P_EU_NORMAL, SBAI_P_EU_SYSTEM: s = SBAI_B_INSTR;
      SBAI_P_BIND_TABLE, SBAI_P_SURF_STATE: s = SBAI_B_SURFACE;
      SBAI_P_MEDIA_IND: s = SBAI_B_INDIRECT;
      default: s = SBAI_B_NONE;
    endcase
    return '{1'b1, r.write, r.path != SBAI_P_PHYSICAL, s, base[s] + r.offset};
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    if (a == SBAI_OFS_MODE) return {31'h0, mode};
    if (a == SBAI_OFS_STATUS) return {13'h0, last_s, 16'(n_req)};
    if (a > SBAI_OFS_MODE) return 32'h0;
    return a[2] ? {16'h0, base[a[7:3] + 1][47:32]} : base[a[7:3] + 1][31:0];
  endfunction
  // shadow copy of the register file, only mapped writable words
  function automatic void apply(input logic [7:0] a, input logic [31:0] d);
    if (a == SBAI_OFS_MODE) mode = d[0];
    else if (a[2]) base[a[7:3] + 1][47:32] = d[15:0];
    else base[a[7:3] + 1][31:0] = d;
  endfunction
  task automatic cmp_mem(input sbai_mem_type got, input sbai_mem_type exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: mem_out %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_cmd_in <= '{1'b1, 1'b0, a, d};
    if (a <= SBAI_OFS_MODE) apply(a, d);
    @(posedge ref_clk_in);
    reg_cmd_in <= '0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge ref_clk_in);
    reg_cmd_in <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk_in);
    reg_cmd_in <= '0;
    #1 cmp_word(reg_rdata_out, exp_rd(a));
  endtask
  // requests every cycle when walking, random gaps otherwise, optional register writes beside them; a write in
  // the same cycle must not affect that request, so expect before applying
  task automatic burst(input int n, input bit walk, input bit wr_too);
    sbai_req_type r;
    sbai_mem_type e;
    sbai_mem_type pe;
    logic [7:0] a;
    logic [31:0] d;
    bit pend;
    pend = 1'b0;
    for (int i = 0; i <= n; i++) begin
      @(posedge ref_clk_in);
      r = '0;
      a = 8'(4 * $urandom_range(10));
      d = $urandom;
      if (i < n) begin
        r.valid = walk || ($urandom_range(3) != 0);
        r.path = sbai_path_type'(walk ? i % 17 : $urandom_range(16));
        r.write = 1'($urandom);
        r.offset = {16'($urandom), $urandom};
      end
      e = exp_mem(r);
      if (wr_too && i < n && $urandom_range(2) == 0) begin
        reg_cmd_in <= '{1'b1, 1'b0, a, d};
        apply(a, d);
      end else reg_cmd_in <= '0;
      req_in <= r;
      n_req += int'(r.valid);
      if (r.valid) last_s = e.base_sel;
      #1 if (pend) cmp_mem(mem_out, pe);
      pend = r.valid;
      pe = e;
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #(3000 * 100);
    n_mismatch++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(88));
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    for (int i = 0; i <= 10; i++) reg_rd(8'(4 * i));
    burst(17, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++) reg_wr(8'(4 * i), $urandom);
    reg_wr(8'h40, 32'h1234_5678);
    reg_wr(SBAI_OFS_STATUS, 32'hffff_ffff);
    for (int i = 0; i <= 12; i++) reg_rd(8'(4 * i));
    burst(17, 1'b1, 1'b0);
    reg_wr(SBAI_OFS_MODE, 32'h1);
    burst(17, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++) reg_wr(8'(4 * i), 32'hffff_ffff);
    burst(17, 1'b1, 1'b0);
    burst(400, 1'b0, 1'b1);
    @(posedge ref_clk_in);
    #1 cmp_word({16'h0, sink_count}, 32'(n_req & 16'hffff));
    reg_rd(SBAI_OFS_STATUS);
    summarize();
  end
endmodule
`default_nettype wire
